// ==== logic/obcl_defines.svh ====
// Address map, reset values and field positions of the option byte store
`ifndef OBCL_DEFINES_SVH
`define OBCL_DEFINES_SVH

`define OBCL_ADDR_RDP       16'h4800
`define OBCL_ADDR_UBC       16'h4802
`define OBCL_ADDR_RSVD      16'h4807
`define OBCL_ADDR_WDG       16'h4808
`define OBCL_ADDR_OSC       16'h4809
`define OBCL_ADDR_BOR       16'h480A
`define OBCL_ADDR_BSL       16'h480B
`define OBCL_ADDR_BSH       16'h480C
`define OBCL_ADDR_RSTVEC    16'h8000

`define OBCL_RST_RDP        8'hAA
`define OBCL_RST_ZERO       8'h00
`define OBCL_RDP_OFF        8'hAA

`define OBCL_UBC_NONE       8'h00
`define OBCL_UBC_VECT       8'h01
`define OBCL_UBC_P01_RW     8'h02
`define OBCL_UBC_P02        8'h03
`define OBCL_UBC_TOP        8'hFF
`define OBCL_UBC_TOP_PAGE   8'hFE

`define OBCL_WDG_IHW        0
`define OBCL_WDG_IHALT      1
`define OBCL_WDG_WHW        2
`define OBCL_WDG_WHALT      3
`define OBCL_WDG_MASK       8'h0F
`define OBCL_OSC_FAST_LSB   0
`define OBCL_OSC_SLOW_LSB   2
`define OBCL_OSC_MASK       8'h0F
`define OBCL_BOR_EN         0
`define OBCL_BROWNOUT_THRESHOLD_LSB     1
`define OBCL_BOR_MASK       8'h0F

`define OBCL_CNT_C0         13'd1
`define OBCL_CNT_C1         13'd16
`define OBCL_CNT_C2         13'd512
`define OBCL_CNT_C3         13'd4096

`define OBCL_BL_ERASED      16'h0000
`define OBCL_VEC_ERASED     8'h00

`endif

// ==== logic/obcl_loader.sv ====
// Option byte store, write arbitration and reset-time configuration latch
//
// Function
// - Option bytes live in dedicated memory
// - Programmer writes any mapped byte in IN_CIRCUIT_PROGRAMMING mode
// - IN_APPLICATION_PROGRAMMING protection and boot-size writes not applied
// - Protection off only for value AA
// - Decode boot code area size byte
// - Bit 0: independent dog hardware start
// - Bit 1: independent dog stops in halt
// - Bit 2: window dog hardware start
// - Bit 3: window dog resets on halt
// - Fast oscillator settle count 1/16/512/4096
// - Slow oscillator settle count same mapping
// - Brownout enable bit and threshold field
// - Boot select checks option and reset vector
`timescale 1ns/1ps
`default_nettype none
`include "obcl_defines.svh"
module obcl_loader #(
    parameter int NBYTES = 13
) (
    input  wire logic                core_clk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    input  wire logic                icp_we_i,
    input  wire logic [15:0]         icp_addr_i,
    input  wire logic [7:0]          icp_wdata_i,
    input  wire logic                iap_we_i,
    input  wire logic [15:0]         iap_addr_i,
    input  wire logic [7:0]          iap_wdata_i,
    input  wire logic [15:0]         rd_addr_i,
    input  wire logic [7:0]          reset_vector_byte_i,
    output logic [7:0]               rd_data_o,
    output logic                     iap_busy_o,
    output logic                     cfg_valid_o,
    output obcl_pkg::obcl_cfg_t      cfg_o
);
    import obcl_pkg::*;

    localparam logic [15:0] BASE = `OBCL_ADDR_RDP;
    localparam logic [15:0] LAST = `OBCL_ADDR_BSH;

    obcl_wr_if wr ();

    logic [7:0] icp_rdp;
    logic [7:0] icp_ubc;

    obcl_store #(
        .NBYTES (NBYTES)
    ) u_store (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .wr         (wr),
        .icp_rdp_o  (icp_rdp),
        .icp_ubc_o  (icp_ubc)
    );

    function automatic logic in_map(input logic [15:0] a);
        in_map = (a >= BASE) && (a <= LAST) && (a != `OBCL_ADDR_RSVD)
                 && (a != BASE + 16'h0001)
                 && (a < BASE + 16'h0003 || a > BASE + 16'h0006);
    endfunction : in_map

    function automatic logic [12:0] settle(input logic [1:0] code);
        logic [12:0] n;
        n = `OBCL_CNT_C0;
        unique case (code)
            2'b00: n = `OBCL_CNT_C0;
            2'b01: n = `OBCL_CNT_C1;
            2'b10: n = `OBCL_CNT_C2;
            2'b11: n = `OBCL_CNT_C3;
        endcase
        return n;
    endfunction : settle

    // Write arbitration: programmer link wins, application write is dropped and flagged busy
    logic        icp_hit;
    logic        iap_hit;
    always_comb begin
        icp_hit  = icp_we_i && in_map(icp_addr_i);
        iap_hit  = iap_we_i && in_map(iap_addr_i);
        wr.we    = ce_i && (icp_hit || iap_hit);
        wr.in_circuit_programming   = icp_hit;
        wr.idx   = icp_hit ? 4'(icp_addr_i - BASE) : 4'(iap_addr_i - BASE);
        wr.wdata = icp_hit ? icp_wdata_i : iap_wdata_i;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            iap_busy_o <= 1'b0;
        end else if (ce_i) begin
            iap_busy_o <= icp_hit && iap_we_i;
        end
    end

    // Reset sequence walks the array once, then the fields freeze
    typedef enum logic [1:0] {
        OBCL_IDLE,
        OBCL_LOAD,
        OBCL_DONE
    } obcl_state_t;

    obcl_state_t state_r;
    obcl_state_t state_nxt;
    logic [3:0]  ptr_r;
    logic [7:0]  img_r [NBYTES];

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            OBCL_IDLE: state_nxt = OBCL_LOAD;
            OBCL_LOAD: begin
                if (ptr_r == 4'(NBYTES - 1)) begin
                    state_nxt = OBCL_DONE;
                end
            end
            OBCL_DONE: state_nxt = OBCL_DONE;
            default:   state_nxt = OBCL_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_r <= OBCL_IDLE;
        end else if (ce_i) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ptr_r <= 4'h0;
        end else if (ce_i && state_r == OBCL_LOAD) begin
            ptr_r <= ptr_r + 4'h1;
        end
    end

    // Read port shared: loader owns it until done, then the bus reads
    always_comb begin
        if (state_r == OBCL_DONE) begin
            wr.ridx = 4'(rd_addr_i - BASE);
        end else begin
            wr.ridx = ptr_r;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (ce_i && state_r == OBCL_LOAD) begin
            img_r[ptr_r] <= wr.rdata;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_data_o <= `OBCL_RST_ZERO;
        end else if (ce_i) begin
            if (state_r == OBCL_DONE && in_map(rd_addr_i)) begin
                rd_data_o <= wr.rdata;
            end else begin
                rd_data_o <= `OBCL_RST_ZERO;
            end
        end
    end

    // Decode from the loaded image; protection fields use IN_CIRCUIT_PROGRAMMING copy
    logic [7:0] rdp_b;
    logic [7:0] ubc_b;
    logic [7:0] wdg_b;
    logic [7:0] osc_b;
    logic [7:0] bor_b;
    logic [15:0] bl_w;
    obcl_cfg_t  dec;

    always_comb begin
        rdp_b = icp_rdp;
        ubc_b = icp_ubc;
        wdg_b = img_r[4'(`OBCL_ADDR_WDG - BASE)] & `OBCL_WDG_MASK;
        osc_b = img_r[4'(`OBCL_ADDR_OSC - BASE)] & `OBCL_OSC_MASK;
        bor_b = img_r[4'(`OBCL_ADDR_BOR - BASE)] & `OBCL_BOR_MASK;
        bl_w  = {img_r[4'(`OBCL_ADDR_BSH - BASE)],
                 img_r[4'(`OBCL_ADDR_BSL - BASE)]};
        dec = '0;
        dec.readout_protect      = (rdp_b != `OBCL_RDP_OFF);
        dec.boot_code_area_size  = ubc_b;
        dec.boot_area_rw_protect = (ubc_b == `OBCL_UBC_P01_RW);
        dec.boot_area_wr_protect = (ubc_b >= `OBCL_UBC_P02);
        if (ubc_b == `OBCL_UBC_NONE || ubc_b == `OBCL_UBC_VECT) begin
            dec.boot_area_last_page = `OBCL_UBC_NONE;
        end else if (ubc_b == `OBCL_UBC_TOP) begin
            dec.boot_area_last_page = `OBCL_UBC_TOP_PAGE;
        end else begin
            dec.boot_area_last_page = ubc_b - 8'h01;
        end
        dec.indep_dog_hw_start      = wdg_b[`OBCL_WDG_IHW];
        dec.indep_dog_lowpower_stop = wdg_b[`OBCL_WDG_IHALT];
        dec.window_dog_hw_start     = wdg_b[`OBCL_WDG_WHW];
        dec.window_dog_halt_reset   = wdg_b[`OBCL_WDG_WHALT];
        dec.fast_osc_settle_count   =
            settle(osc_b[`OBCL_OSC_FAST_LSB +: 2]);
        dec.slow_osc_settle_count   =
            settle(osc_b[`OBCL_OSC_SLOW_LSB +: 2]);
        dec.brownout_enable    = bor_b[`OBCL_BOR_EN];
        dec.brownout_threshold = bor_b[`OBCL_BROWNOUT_THRESHOLD_LSB +: 3];
        // Non-erased option, or erased vector, sends boot to the loader
        dec.boot_to_loader = (bl_w != `OBCL_BL_ERASED) ||
            (reset_vector_byte_i == `OBCL_VEC_ERASED);
    end

    // Captured once per reset; later writes wait for the next reset
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cfg_valid_o <= 1'b0;
        end else if (ce_i && state_r == OBCL_LOAD &&
                     state_nxt == OBCL_DONE) begin
            cfg_valid_o <= 1'b1;
        end else if (ce_i && state_r == OBCL_DONE && !cfg_valid_o) begin
            cfg_valid_o <= 1'b0;
        end
    end

    logic cap_r;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cap_r <= 1'b0;
        end else if (ce_i) begin
            cap_r <= cfg_valid_o;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cfg_o <= '0;
        end else if (ce_i && cfg_valid_o && !cap_r) begin
            cfg_o <= dec;
        end
    end
endmodule : obcl_loader
`default_nettype wire

// ==== logic/obcl_pkg.sv ====
// Types shared by the option byte loader
package obcl_pkg;
    typedef enum logic [1:0] {
        OBCL_SRC_NONE,
        OBCL_SRC_ICP,
        OBCL_SRC_IAP
    } obcl_src_t;

    typedef struct packed {
        logic        readout_protect;
        logic [7:0]  boot_code_area_size;
        logic [7:0]  boot_area_last_page;
        logic        boot_area_rw_protect;
        logic        boot_area_wr_protect;
        logic        indep_dog_hw_start;
        logic        indep_dog_lowpower_stop;
        logic        window_dog_hw_start;
        logic        window_dog_halt_reset;
        logic [12:0] fast_osc_settle_count;
        logic [12:0] slow_osc_settle_count;
        logic        brownout_enable;
        logic [2:0]  brownout_threshold;
        logic        boot_to_loader;
    } obcl_cfg_t;
endpackage : obcl_pkg

// ==== logic/obcl_store.sv ====
// Non-volatile option byte array with IN_CIRCUIT_PROGRAMMING shadow copies of the RDP and UBC bytes only
`timescale 1ns/1ps
`default_nettype none
`include "obcl_defines.svh"
module obcl_store #(
    parameter int NBYTES = 13
) (
    input  wire logic  core_clk_i,
    input  wire logic  rst_i,
    input  wire logic  ce_i,
    obcl_wr_if.store   wr,
    output logic [7:0] icp_rdp_o,
    output logic [7:0] icp_ubc_o
);
    import obcl_pkg::*;

    // Separate array from program memory, survives system reset
    logic [7:0] mem_r [NBYTES];
    logic [7:0] icp_rdp_r;
    logic [7:0] icp_ubc_r;
    // Power-up value only; system reset must not re-arm it
    logic       init_r = 1'b0;

    always_ff @(posedge core_clk_i) begin
        if (ce_i) begin
            if (!init_r) begin
                for (int i = 0; i < NBYTES; i++) begin
                    mem_r[i] <= `OBCL_RST_ZERO;
                end
                mem_r[0] <= `OBCL_RST_RDP;
            end else if (wr.we) begin
                mem_r[wr.idx] <= wr.wdata;
            end
        end
    end

    // Only the power-up image clears these, so reset keeps the content
    always_ff @(posedge core_clk_i) begin
        if (ce_i) begin
            if (!init_r) begin
                icp_rdp_r <= `OBCL_RST_RDP;
                icp_ubc_r <= `OBCL_RST_ZERO;
            end else if (wr.we && wr.in_circuit_programming) begin
                if (wr.idx == 4'(`OBCL_ADDR_RDP - `OBCL_ADDR_RDP)) begin
                    icp_rdp_r <= wr.wdata;
                end
                if (wr.idx == 4'(`OBCL_ADDR_UBC - `OBCL_ADDR_RDP)) begin
                    icp_ubc_r <= wr.wdata;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (ce_i && !rst_i) begin
            init_r <= 1'b1;
        end
    end

    assign wr.rdata  = mem_r[wr.ridx];
    assign icp_rdp_o = icp_rdp_r;
    assign icp_ubc_o = icp_ubc_r;
endmodule : obcl_store
`default_nettype wire

// ==== logic/obcl_wr_if.sv ====
// Write channel from the access arbiter to the option byte array
`timescale 1ns/1ps
`default_nettype none
interface obcl_wr_if;
    logic       we;
    logic [3:0] idx;
    logic [7:0] wdata;
    logic       in_circuit_programming;
    logic [7:0] rdata;
    logic [3:0] ridx;
    modport master (output we, output idx, output wdata, output in_circuit_programming,
                    output ridx, input rdata);
    modport store  (input we, input idx, input wdata, input in_circuit_programming,
                    input ridx, output rdata);
endinterface : obcl_wr_if
`default_nettype wire

// ==== testbench/obcl_loader_monitor.sv ====
// Port checker for the option byte loader
`timescale 1ns/1ps
`default_nettype none
module obcl_loader_monitor #(
    parameter int NBYTES = 13
) (
    input wire logic                core_clk_i,
    input wire logic                rst_i,
    input wire logic                ce_i,
    input wire logic                icp_we_i,
    input wire logic [15:0]         icp_addr_i,
    input wire logic                iap_we_i,
    input wire logic [15:0]         iap_addr_i,
    input wire logic [15:0]         rd_addr_i,
    input wire logic [7:0]          rd_data_o,
    input wire logic                iap_busy_o,
    input wire logic                cfg_valid_o,
    input wire obcl_pkg::obcl_cfg_t cfg_o
);
    import obcl_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    function automatic logic mapped(input logic [15:0] a);
        // Reserved byte is neither stored nor read back
        return a == 16'h4800 || a == 16'h4802 ||
               (a >= 16'h4808 && a <= 16'h480C);
    endfunction : mapped
    // Config lags valid by one edge, so judge it from the third valid edge on
    sequence s_settled;
        cfg_valid_o && $past(cfg_valid_o, 2);
    endsequence
    sequence s_load;
        ##[1:20] cfg_valid_o;
    endsequence
    a_load_bound: assert property ($fell(rst_i) |-> s_load)
        else $error("config load late");
    a_cfg_held: assert property (s_settled |-> $stable(cfg_o))
        else $error("config changed without reset");
    a_cfg_early: assert property (!cfg_valid_o |-> cfg_o == '0)
        else $error("config shown before load");
    a_fast_count: assert property (
        s_settled |-> cfg_o.fast_osc_settle_count inside
        {13'h0001, 13'h0010, 13'h0200, 13'h1000})
        else $error("bad settle count");
    a_ubc_top: assert property (s_settled ##0
        (cfg_o.boot_code_area_size == 8'hFF) |-> cfg_o.boot_area_last_page
        == 8'hFE && cfg_o.boot_area_wr_protect) else $error("top size");
    a_ubc_two: assert property (s_settled ##0
        (cfg_o.boot_code_area_size == 8'h02) |-> cfg_o.boot_area_last_page
        == 8'h01 && cfg_o.boot_area_rw_protect) else $error("size two");
    a_busy_set: assert property (icp_we_i && iap_we_i && ce_i
        && mapped(icp_addr_i) && mapped(iap_addr_i) |=> iap_busy_o)
        else $error("collision not flagged");
    a_busy_cause: assert property (iap_busy_o |->
        $past(icp_we_i) && $past(iap_we_i)) else $error("spurious busy");
    a_rd_unmapped: assert property (cfg_valid_o && ce_i
        && !mapped(rd_addr_i) |=> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
endmodule : obcl_loader_monitor
bind obcl_loader obcl_loader_monitor #(.NBYTES(NBYTES)) u_mon (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .icp_we_i(icp_we_i), .icp_addr_i(icp_addr_i), .iap_we_i(iap_we_i),
    .iap_addr_i(iap_addr_i), .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o), .iap_busy_o(iap_busy_o),
    .cfg_valid_o(cfg_valid_o), .cfg_o(cfg_o)
);
`default_nettype wire

// ==== testbench/obcl_prog_model.sv ====
// Behavioural programmer writing option bytes over the debug link
`timescale 1ns/1ps
`default_nettype none
module obcl_prog_model (
    input  wire logic   core_clk_i,
    output logic        icp_we_o,
    output logic [15:0] icp_addr_o,
    output logic [7:0]  icp_wdata_o
);
    initial begin
        icp_we_o = 1'b0;
        icp_addr_o = 16'hFFFF;
        icp_wdata_o = 8'h55;
    end
    // Gap models a slow link between bytes
    task automatic write_byte(input logic [15:0] a, input logic [7:0] d,
                              input int gap);
        @(posedge core_clk_i);
        icp_we_o <= 1'b1;
        icp_addr_o <= a;
        icp_wdata_o <= d;
        @(posedge core_clk_i);
        icp_we_o <= 1'b0;
        // Released lines invert so stale values never pass as fresh
        icp_addr_o <= ~a;
        icp_wdata_o <= ~d;
        repeat (gap) @(posedge core_clk_i);
    endtask : write_byte
endmodule : obcl_prog_model
`default_nettype wire

// ==== testbench/tb_option_byte_config_loader.sv ====
// Self-checking bench for the option byte configuration loader
`timescale 1ns/1ps
`default_nettype none
module tb_option_byte_config_loader;
    import obcl_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic        icp_we_i;
    logic [15:0] icp_addr_i;
    logic [7:0]  icp_wdata_i;
    logic        iap_we_i = 1'b0;
    logic [15:0] iap_addr_i = 16'hFFFF;
    logic [7:0]  iap_wdata_i = 8'h00;
    logic [15:0] rd_addr_i = 16'h0000;
    logic [7:0]  vec_byte = 8'h82;
    logic [7:0]  rd_data_o;
    logic        iap_busy_o;
    logic        cfg_valid_o;
    obcl_cfg_t   cfg_o;
    logic [3:0]  wdg;
    int          miscompares = 0;
    int          checks = 0;
    assign wdg = {cfg_o.window_dog_halt_reset, cfg_o.window_dog_hw_start,
                  cfg_o.indep_dog_lowpower_stop, cfg_o.indep_dog_hw_start};
    always #5 core_clk_i = ~core_clk_i;
    obcl_prog_model u_prog (.core_clk_i(core_clk_i), .icp_we_o(icp_we_i),
        .icp_addr_o(icp_addr_i), .icp_wdata_o(icp_wdata_i));
    obcl_loader #(.NBYTES(13)) u_obcl_loader (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .ce_i(ce_i), .icp_we_i(icp_we_i),
        .icp_addr_i(icp_addr_i), .icp_wdata_i(icp_wdata_i),
        .iap_we_i(iap_we_i), .iap_addr_i(iap_addr_i),
        .iap_wdata_i(iap_wdata_i), .rd_addr_i(rd_addr_i),
        .reset_vector_byte_i(vec_byte), .rd_data_o(rd_data_o),
        .iap_busy_o(iap_busy_o), .cfg_valid_o(cfg_valid_o), .cfg_o(cfg_o));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task automatic wait_cfg;
        int n;
        for (n = 0; n < 40 && cfg_valid_o !== 1'b1; n++)
            @(posedge core_clk_i);
        if (n == 40) begin
            miscompares++;
            close_out();
        end
        // Config lands one edge after valid
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask : wait_cfg
    task automatic do_reset;
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        wait_cfg();
    endtask : do_reset
    task automatic app_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        iap_we_i <= 1'b1;
        iap_addr_i <= a;
        iap_wdata_i <= d;
        @(posedge core_clk_i);
        iap_we_i <= 1'b0;
        iap_addr_i <= ~a;
        iap_wdata_i <= ~d;
    endtask : app_wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        rd_addr_i <= a;
        @(posedge core_clk_i);
        #1 chk(16'(rd_data_o), 16'(e));
    endtask : rd
    task automatic t_defaults;
        logic [15:0] a[8] = '{16'h4800, 16'h4802, 16'h4807, 16'h4808,
                              16'h4809, 16'h480A, 16'h480B, 16'h480C};
        for (int i = 0; i < 8; i++)
            rd(a[i], (i == 0) ? 8'hAA : 8'h00);
        rd(16'h8000, 8'h00);
        chk(16'(cfg_o.readout_protect), 16'h0000);
        chk(16'(cfg_o.fast_osc_settle_count), 16'h0001);
        chk(16'(cfg_o.brownout_enable), 16'h0000);
        chk(16'(cfg_o.boot_to_loader), 16'h0000);
        $display("test defaults done");
    endtask : t_defaults
    task automatic t_wdg_osc;
        logic [12:0] cnt[4] = '{13'h0001, 13'h0010, 13'h0200, 13'h1000};
        for (int k = 0; k < 4; k++) begin
            u_prog.write_byte(16'h4808, 8'h01 << k, k);
            u_prog.write_byte(16'h4809, 8'(((3 - k) << 2) | k), 0);
            do_reset();
            chk(16'(wdg), 16'h0001 << k);
            chk(16'(cfg_o.fast_osc_settle_count), 16'(cnt[k]));
            chk(16'(cfg_o.slow_osc_settle_count), 16'(cnt[3 - k]));
        end
        $display("test watchdog and oscillator done");
    endtask : t_wdg_osc
    task automatic t_bor_boot;
        u_prog.write_byte(16'h480A, 8'h0B, 2);
        u_prog.write_byte(16'h480C, 8'h01, 0);
        do_reset();
        chk(16'(cfg_o.brownout_enable), 16'h0001);
        chk(16'(cfg_o.brownout_threshold), 16'h0005);
        chk(16'(cfg_o.boot_to_loader), 16'h0001);
        u_prog.write_byte(16'h480C, 8'h00, 0);
        vec_byte <= 8'h00;
        do_reset();
        chk(16'(cfg_o.boot_to_loader), 16'h0001);
        vec_byte <= 8'h82;
        $display("test brownout and boot done");
    endtask : t_bor_boot
    task automatic t_rdp_ubc;
        u_prog.write_byte(16'h4800, 8'h00, 0);
        u_prog.write_byte(16'h4802, 8'hFF, 0);
        do_reset();
        chk(16'(cfg_o.readout_protect), 16'h0001);
        chk(16'(cfg_o.boot_area_last_page), 16'h00FE);
        app_wr(16'h4800, 8'hAA);
        app_wr(16'h4802, 8'h02);
        app_wr(16'h4808, 8'h0F);
        do_reset();
        chk(16'(cfg_o.readout_protect), 16'h0001);
        chk(16'(cfg_o.boot_code_area_size), 16'h00FF);
        chk(16'(wdg), 16'h000F);
        u_prog.write_byte(16'h4800, 8'hAA, 0);
        u_prog.write_byte(16'h4802, 8'h02, 0);
        do_reset();
        chk(16'(cfg_o.readout_protect), 16'h0000);
        chk(16'(cfg_o.boot_area_last_page), 16'h0001);
        chk(16'(cfg_o.boot_area_rw_protect), 16'h0001);
        $display("test protection and boot size done");
    endtask : t_rdp_ubc
    task automatic t_hold_collide;
        u_prog.write_byte(16'h4801, 8'h5A, 0);
        rd(16'h4801, 8'h00);
        fork
            u_prog.write_byte(16'h4808, 8'h00, 0);
            app_wr(16'h4809, 8'h0C);
        join
        #1 chk(16'(iap_busy_o), 16'h0001);
        rd(16'h4809, 8'h03);
        rd(16'h4808, 8'h00);
        // Frozen clock enable must swallow a programmer write
        ce_i <= 1'b0;
        u_prog.write_byte(16'h4809, 8'h0F, 0);
        ce_i <= 1'b1;
        rd(16'h4809, 8'h03);
        chk(16'(wdg), 16'h000F);
        $display("test hold and collision done");
    endtask : t_hold_collide
    initial begin
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        wait_cfg();
        t_defaults();
        t_wdg_osc();
        t_bor_boot();
        t_rdp_ubc();
        t_hold_collide();
        close_out();
    end
endmodule : tb_option_byte_config_loader
`default_nettype wire
